// [hdl/trace_port_map.svh]
// Register offsets, field positions and reset values of the trace port.
// Assumes byte addresses on a 32-bit APB with one word per register.
`ifndef TRACE_PORT_MAP_SVH
`define TRACE_PORT_MAP_SVH
`define OFS_CTRL 8'h00
`define OFS_CONTEXT 8'h04
`define OFS_STATUS 8'h08
`define OFS_COUNT 8'h0C
`define CTRL_FORCE_BIT 0
`define CTRL_CTXCLR_BIT 1
`define CTRL_RST 2'h0
`define CONTEXT_RST 32'h0000_0000
`define STAT_EMPTY_BIT 0
`define STAT_BLOCK_BIT 1
`define STAT_STATE_LSB 2
`define STAT_CNT_LSB 8
`endif

// [hdl/trace_port_pkg.sv]
// Types shared by the waypoint trace port.
// Assumes nothing of its surroundings.
package trace_port_pkg;
    typedef enum logic [2:0] {
        KIND_DIRECT = 3'h0,
        KIND_INDIRECT = 3'h1,
        KIND_EXCEPT = 3'h2,
        KIND_BARRIER = 3'h3,
        KIND_DBG_ENTRY = 3'h4,
        KIND_DBG_EXIT = 3'h5,
        KIND_BAD6 = 3'h6,
        KIND_BAD7 = 3'h7
    } point_kind_t;

    typedef enum logic [3:0] {
        EXC_NONE = 4'h0,
        EXC_HALT_DBG = 4'h1,
        EXC_MONITOR = 4'h2,
        EXC_IMP_ABORT = 4'h4,
        EXC_ENV_TRAP = 4'h5,
        EXC_RESET = 4'h8,
        EXC_UNDEF = 4'h9,
        EXC_SVC = 4'hA,
        EXC_PREFETCH = 4'hB,
        EXC_DATA_ABORT = 4'hC,
        EXC_IRQ = 4'hD,
        EXC_FIQ = 4'hF
    } exc_kind_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_BLOCK = 3'b010,
        ST_DEBUG = 3'b100
    } port_state_t;
endpackage

// [hdl/waypoint_trace_port.sv]
// Waypoint trace port: formats core waypoints for a program trace unit.
// Assumes core-side inputs and the APB master are synchronous to pclk.
//
// How it works
// - Two-bit output reports waypoints committed each cycle while trace_point_enable is high, zero otherwise; valid and commit may coincide.
// - 32-bit context identifier with each waypoint; zero until software has set it.
// - Exception kind uses the fixed four-bit code table of the package.
// - Link-update flag only on link-writing direct or indirect branches.
// - Last address is the pc, link base for exceptions, zero for reset.
// - In compact state, show instruction size: 0 short, 1 wide.
// - Condition-passed flag follows the core for branches, set for others.
// - Destination bit 1 cleared without compact bit, bit 0 without bytecode bit.
// - Destination reads zero for prohibited or debug entry/exit waypoints.
// - Both destination state bits are output with each waypoint.
// - Entering prohibition flags exactly one valid waypoint, then emission stops.
// - Both debug enables low and queue drained: blocked flag held asserted.
// - First waypoint after prohibition is marked as synchronisation start.
// - Three-bit waypoint kind codes; codes six and seven are never emitted.
// - Every debug entry taken while not prohibited is followed by a debug exit.
// - Non-secure output is nonsecure flag and not monitor mode.
// - Queue-empty output high when no speculative waypoints are held.
// - Valid output only for confirmed waypoints.
// - All ports except the asynchronous presetn are timed on the rising pclk edge.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`include "trace_port_map.svh"

module waypoint_trace_port
    import trace_port_pkg::*;
#(
    parameter int CNT_W = 4
) (
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic core_wp_valid, // Confirmed waypoint offered
    input wire logic [2:0] core_kind, // Waypoint kind
    input wire logic [3:0] core_exc, // Exception kind
    input wire logic [31:0] core_pc, // Last executed address
    input wire logic [31:0] core_lr, // Link base for exceptions
    input wire logic [31:0] core_target, // Destination address
    input wire logic core_tbit, // Destination compact state
    input wire logic core_jbit, // Destination bytecode state
    input wire logic core_compact, // Current compact state
    input wire logic core_wide, // Last instruction is 32-bit
    input wire logic core_link, // Branch writes link register
    input wire logic core_cond, // Condition codes passed
    input wire logic core_prohibit, // Destination is prohibited
    input wire logic core_monitor, // Secure monitor mode
    input wire logic nonsecure_flag, // Security state flag
    input wire logic [1:0] core_commit, // Waypoints committed now
    input wire logic core_spec_push, // Speculative waypoint entered
    input wire logic core_spec_pop, // Speculative waypoint left
    input wire logic core_flush, // Discard speculative waypoints
    input wire logic invasive_dbg_en, // Invasive debug enable
    input wire logic noninvasive_dbg_en, // Noninvasive debug enable
    input wire logic trace_point_enable, // Enable from trace unit
    output logic trace_point_valid, // Waypoint valid
    output logic [2:0] trace_point_kind, // Waypoint kind
    output logic [1:0] trace_commit_count, // Committed count
    output logic [31:0] trace_context_ident, // Context identifier
    output logic [3:0] trace_exception_kind, // Exception kind
    output logic trace_discard, // Flush to trace unit
    output logic trace_link_update, // Branch updates link
    output logic [31:0] trace_last_addr, // Last executed address
    output logic trace_wide_instr, // 32-bit instruction
    output logic trace_cond_passed, // Condition passed
    output logic dest_bytecode_bit, // Destination bytecode bit
    output logic dest_compact_bit, // Destination compact bit
    output logic [31:0] trace_dest_addr, // Destination address
    output logic trace_blocked, // Trace prohibited
    output logic trace_sync_start, // Waypoint is sync start
    output logic trace_nonsecure, // Non-secure after waypoint
    output logic trace_queue_empty // No speculative waypoints
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic is_branch(input logic [2:0] k);
        is_branch = (k == KIND_DIRECT) || (k == KIND_INDIRECT);
    endfunction

    function automatic logic is_debug(input logic [2:0] k);
        is_debug = (k == KIND_DBG_ENTRY) || (k == KIND_DBG_EXIT);
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Software registers
    logic [1:0] ctrl_r;
    logic [31:0] ctx_r;
    logic [31:0] emit_cnt_r;

    // Sequencer and queue depth
    logic [CNT_W-1:0] spec_cnt_r;
    logic [CNT_W-1:0] spec_cnt_nxt;
    port_state_t st_r;
    port_state_t st_nxt;

    // APB answer
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // Output stage
    logic valid_r;
    logic [2:0] kind_r;
    logic [1:0] commit_r;
    logic [3:0] exc_r;
    logic discard_r;
    logic link_r;
    logic [31:0] last_r;
    logic wide_r;
    logic cond_r;
    logic jbit_r;
    logic tbit_r;
    logic [31:0] dest_r;

    // Prohibition, sync, security and queue status
    logic blocked_r;
    logic sync_r;
    logic sync_due_r;
    logic nsec_r;
    logic empty_r;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire setup = psel & ~penable & ~pready_r;
    wire wr_now = psel & penable & pready_r & pwrite;

    wire hit_ctrl = paddr == `OFS_CTRL;
    wire hit_ctx = paddr == `OFS_CONTEXT;
    wire hit_stat = paddr == `OFS_STATUS;
    wire hit_cnt = paddr == `OFS_COUNT;
    wire hit_any = hit_ctrl | hit_ctx | hit_stat | hit_cnt;

    wire ro_write = pwrite & (hit_stat | hit_cnt);
    wire ctx_clr = wr_now & hit_ctrl & pwdata[`CTRL_CTXCLR_BIT];
    wire ctx_wr = wr_now & hit_ctx;
    wire force_block = ctrl_r[`CTRL_FORCE_BIT];

    // Empty, blocked, state, queue depth
    wire [31:0] status_word = {
        {(24 - CNT_W){1'b0}},
        spec_cnt_r,
        {(6 - $bits(st_r)){1'b0}},
        st_r,
        blocked_r,
        empty_r
    };

    wire [31:0] rd_word =
        hit_ctrl ? {30'h0, ctrl_r} :
        hit_ctx ? ctx_r :
        hit_stat ? status_word :
        hit_cnt ? emit_cnt_r : 32'h0;

    // ------------------------------------------------------------
    // Waypoint qualification and formatting
    // ------------------------------------------------------------
    wire kind_ok = ~core_kind[2] | ~core_kind[1];
    wire take = core_wp_valid & kind_ok & trace_point_enable;
    wire dbg_off = ~invasive_dbg_en & ~noninvasive_dbg_en;
    wire drained = spec_cnt_r == '0;
    wire perm_block = dbg_off & drained;
    // Core, software or debug lockout
    wire prohib = core_prohibit | force_block | dbg_off;

    // In debug state any waypoint taken closes the debug episode
    wire in_debug = st_r == ST_DEBUG;
    wire [2:0] kind_eff = in_debug ? KIND_DBG_EXIT : core_kind;
    wire in_block = st_r == ST_BLOCK;
    wire resume = in_block & take & ~prohib;
    wire enter_blk = (st_r == ST_RUN) & take & prohib;
    wire emit = take & (~in_block | resume);
    wire zero_dest = enter_blk | is_debug(kind_eff);

    // Low bits follow destination state
    wire [31:0] dest_mask = {
        core_target[31:2],
        core_target[1] & core_tbit,
        core_target[0] & core_jbit
    };

    // Exceptions other than reset give the link base
    wire is_exc = kind_eff == KIND_EXCEPT;
    wire is_rst = is_exc & (core_exc == EXC_RESET);
    wire [31:0] last_sel = is_rst ? 32'h0 :
        is_exc ? core_lr : core_pc;

    wire link_sel = core_link & is_branch(kind_eff);
    wire cond_sel = is_branch(kind_eff) ? core_cond : 1'b1;
    wire nsec_sel = nonsecure_flag & ~core_monitor;
    wire wide_sel = core_compact & core_wide;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_RUN: begin
                if (take && prohib) begin
                    st_nxt = ST_BLOCK;
                end else if (take && core_kind == KIND_DBG_ENTRY) begin
                    st_nxt = ST_DEBUG;
                end
            end
            ST_BLOCK: begin
                // A clean waypoint resumes trace
                if (resume) begin
                    st_nxt = (core_kind == KIND_DBG_ENTRY) ? ST_DEBUG : ST_RUN;
                end
            end
            ST_DEBUG: begin
                if (take) begin
                    st_nxt = ST_RUN;
                end
            end
            default: begin
                st_nxt = ST_RUN;
            end
        endcase
    end

    // Speculative queue occupancy
    assign spec_cnt_nxt = core_flush ? '0 :
        spec_cnt_r + CNT_W'(core_spec_push) - CNT_W'(core_spec_pop);

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // Ready one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & (~hit_any | ro_write);
            prdata_r <= (setup & ~pwrite) ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CTRL_RST;
        end else if (wr_now && hit_ctrl) begin
            ctrl_r <= {1'b0, pwdata[`CTRL_FORCE_BIT]};
        end
    end

    // Clear returns the identifier to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctx_r <= `CONTEXT_RST;
        end else if (ctx_wr) begin
            ctx_r <= pwdata;
        end else if (ctx_clr) begin
            ctx_r <= `CONTEXT_RST;
        end
    end

    // ------------------------------------------------------------
    // State, counters and queue status
    // ------------------------------------------------------------
    // Emission count wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RUN;
            spec_cnt_r <= '0;
            empty_r <= 1'b1;
            emit_cnt_r <= 32'h0;
        end else begin
            st_r <= st_nxt;
            spec_cnt_r <= spec_cnt_nxt;
            empty_r <= spec_cnt_nxt == '0;
            emit_cnt_r <= emit_cnt_r + 32'(emit);
        end
    end

    // ------------------------------------------------------------
    // Output stage, all on the rising edge
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_r <= 1'b0;
            commit_r <= 2'h0;
            discard_r <= 1'b0;
            blocked_r <= 1'b0;
            sync_r <= 1'b0;
            sync_due_r <= 1'b0;
        end else begin
            valid_r <= emit;
            commit_r <= trace_point_enable ? core_commit : 2'h0;
            discard_r <= core_flush;
            blocked_r <= enter_blk | (in_block & ~resume) | perm_block;
            if (emit) begin
                // Armed by the blocked waypoint
                sync_r <= sync_due_r;
                sync_due_r <= enter_blk;
            end else begin
                sync_r <= 1'b0;
                sync_due_r <= sync_due_r | enter_blk;
            end
        end
    end

    // Fields hold until the next emit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kind_r <= 3'h0;
            exc_r <= 4'h0;
            link_r <= 1'b0;
            last_r <= 32'h0;
            wide_r <= 1'b0;
            cond_r <= 1'b0;
            jbit_r <= 1'b0;
            tbit_r <= 1'b0;
            dest_r <= 32'h0;
            nsec_r <= 1'b0;
        end else if (emit) begin
            kind_r <= kind_eff;
            exc_r <= is_exc ? core_exc : EXC_NONE;
            link_r <= link_sel;
            last_r <= last_sel;
            wide_r <= wide_sel;
            cond_r <= cond_sel;
            jbit_r <= core_jbit;
            tbit_r <= core_tbit;
            dest_r <= zero_dest ? 32'h0 : dest_mask;
            nsec_r <= nsec_sel;
        end
    end

    // ------------------------------------------------------------
    // Port drive
    // ------------------------------------------------------------
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    assign trace_point_valid = valid_r;
    assign trace_point_kind = kind_r;
    assign trace_commit_count = commit_r;
    assign trace_context_ident = ctx_r;
    assign trace_exception_kind = exc_r;
    assign trace_discard = discard_r;

    assign trace_link_update = link_r;
    assign trace_last_addr = last_r;
    assign trace_wide_instr = wide_r;
    assign trace_cond_passed = cond_r;

    assign dest_bytecode_bit = jbit_r;
    assign dest_compact_bit = tbit_r;
    assign trace_dest_addr = dest_r;

    assign trace_blocked = blocked_r;
    assign trace_sync_start = sync_r;
    assign trace_nonsecure = nsec_r;
    assign trace_queue_empty = empty_r;

endmodule

// [bench/waypoint_trace_port_props.sv]
// Assertions on the waypoint trace port outputs.
// Assumes it is bound to waypoint_trace_port, all ports on pclk.
`timescale 1ns/1ns
module waypoint_trace_port_props
    import trace_port_pkg::*;
(
    input logic pclk, // Clock
    input logic presetn, // Reset, low
    input logic core_wp_valid, // Offered
    input logic [2:0] core_kind, // Kind in
    input logic [1:0] core_commit, // Commit in
    input logic core_link, // Link in
    input logic core_cond, // Cond in
    input logic core_monitor, // Monitor mode
    input logic nonsecure_flag, // Security flag
    input logic core_flush, // Flush in
    input logic core_spec_push, // Push in
    input logic trace_point_enable, // Enable
    input logic trace_point_valid, // Valid
    input logic [2:0] trace_point_kind, // Kind
    input logic [1:0] trace_commit_count, // Commit
    input logic [3:0] trace_exception_kind, // Exception
    input logic trace_link_update, // Link
    input logic [31:0] trace_last_addr, // Last
    input logic trace_cond_passed, // Cond
    input logic dest_bytecode_bit, // Bytecode
    input logic dest_compact_bit, // Compact
    input logic [31:0] trace_dest_addr, // Dest
    input logic trace_blocked, // Blocked
    input logic trace_nonsecure, // Nonsecure
    input logic trace_queue_empty, // Empty
    input logic trace_discard // Discard
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------
    // Checks
    // ----------
    property p_commit;
        1'h1 |=> trace_commit_count == ($past(trace_point_enable) ? $past(core_commit) : 2'h0);
    endproperty
    a_commit: assert property (p_commit) else $error("commit count wrong");
    property p_cause;
        trace_point_valid |-> $past(core_wp_valid && trace_point_enable && core_kind < 3'h6);
    endproperty
    a_cause: assert property (p_cause) else $error("valid without cause");
    property p_link;
        trace_point_valid |-> trace_link_update == ($past(core_link) && trace_point_kind < 3'h2);
    endproperty
    a_link: assert property (p_link) else $error("link flag wrong");
    property p_cond;
        trace_point_valid |-> trace_cond_passed == (trace_point_kind > 3'h1 || $past(core_cond));
    endproperty
    a_cond: assert property (p_cond) else $error("cond flag wrong");
    property p_bits;
        trace_point_valid |-> (dest_compact_bit || !trace_dest_addr[1])
            && (dest_bytecode_bit || !trace_dest_addr[0]);
    endproperty
    a_bits: assert property (p_bits) else $error("dest low bits wrong");
    property p_zero;
        trace_point_valid && (trace_blocked || trace_point_kind inside {3'h4, 3'h5})
            |-> trace_dest_addr == 32'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("dest not zero");
    property p_rst;
        trace_point_valid && trace_point_kind == KIND_EXCEPT && trace_exception_kind == EXC_RESET
            |-> trace_last_addr == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset last addr wrong");
    property p_once;
        trace_point_valid && trace_blocked |=> !(trace_point_valid && trace_blocked);
    endproperty
    a_once: assert property (p_once) else $error("blocked valid repeated");
    property p_ns;
        trace_point_valid |-> trace_nonsecure == $past(nonsecure_flag && !core_monitor);
    endproperty
    a_ns: assert property (p_ns) else $error("nonsecure wrong");
    property p_flush;
        core_flush && !core_spec_push |=> trace_queue_empty && trace_discard;
    endproperty
    a_flush: assert property (p_flush) else $error("flush not seen");
endmodule

// [bench/trace_unit_model.sv]
// Model of the trace unit that takes waypoints from the port.
// Assumes it shares pclk and presetn with the port.
`timescale 1ns/1ns
module trace_unit_model (
    input logic pclk, // Clock
    input logic presetn, // Reset, low
    input logic allow, // Bench wants waypoints
    input logic trace_point_valid, // Valid
    input logic trace_blocked, // Blocked
    input logic trace_sync_start, // Sync marker
    output logic trace_point_enable, // Enable to port
    output logic sync_err // Sync marker missed
);
    logic want_sync_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trace_point_enable <= 1'h0;
            want_sync_r <= 1'h0;
            sync_err <= 1'h0;
        end else begin
            trace_point_enable <= allow;
            if (trace_point_valid) begin
                want_sync_r <= trace_blocked;
                if (want_sync_r && !trace_blocked && !trace_sync_start) begin
                    sync_err <= 1'h1;
                end
            end
        end
    end
endmodule

// [bench/waypoint_trace_port_tb.sv]
// Self-checking bench for the waypoint trace port.
// Assumes the design, its package and register map header.
`timescale 1ns/1ns
`include "trace_port_map.svh"
module waypoint_trace_port_tb
    import trace_port_pkg::*;
;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, core_pc = 32'h0000_1000, core_lr = 32'h0000_2000;
    logic [31:0] core_target = 32'hFFFF_FFFF, trace_context_ident, trace_last_addr, trace_dest_addr;
    logic pready, pslverr, core_wp_valid = 1'h0, core_tbit = 1'h0, core_jbit = 1'h0;
    logic core_compact = 1'h0, core_wide = 1'h1, core_link = 1'h1, core_cond = 1'h0;
    logic core_prohibit = 1'h0, core_monitor = 1'h0, nonsecure_flag = 1'h0, core_spec_push = 1'h0;
    logic core_spec_pop = 1'h0, core_flush = 1'h0, invasive_dbg_en = 1'h1, noninvasive_dbg_en = 1'h1;
    logic [2:0] core_kind = 3'h0, trace_point_kind;
    logic [3:0] core_exc = 4'h0, trace_exception_kind;
    logic [1:0] core_commit = 2'h0, trace_commit_count;
    logic trace_point_enable, trace_point_valid, trace_discard, trace_link_update, trace_wide_instr;
    logic trace_cond_passed, dest_bytecode_bit, dest_compact_bit, trace_blocked, trace_sync_start;
    logic trace_nonsecure, trace_queue_empty, allow = 1'h1, sync_err;
    int bad_count = 0, compares = 0, sent = 0, cycles = 0;
    exc_kind_t excs [11] = '{EXC_HALT_DBG, EXC_MONITOR, EXC_IMP_ABORT, EXC_ENV_TRAP, EXC_RESET,
        EXC_UNDEF, EXC_SVC, EXC_PREFETCH, EXC_DATA_ABORT, EXC_IRQ, EXC_FIQ};
    waypoint_trace_port #(.CNT_W(4)) u_waypoint_trace_port (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_wp_valid, .core_kind,
        .core_exc, .core_pc, .core_lr, .core_target, .core_tbit, .core_jbit, .core_compact,
        .core_wide, .core_link, .core_cond, .core_prohibit, .core_monitor, .nonsecure_flag,
        .core_commit, .core_spec_push, .core_spec_pop, .core_flush, .invasive_dbg_en,
        .noninvasive_dbg_en, .trace_point_enable, .trace_point_valid, .trace_point_kind,
        .trace_commit_count, .trace_context_ident, .trace_exception_kind, .trace_discard,
        .trace_link_update, .trace_last_addr, .trace_wide_instr, .trace_cond_passed,
        .dest_bytecode_bit, .dest_compact_bit, .trace_dest_addr, .trace_blocked,
        .trace_sync_start, .trace_nonsecure, .trace_queue_empty);
    trace_unit_model u_trace_unit_model (.pclk, .presetn, .allow, .trace_point_valid,
        .trace_blocked, .trace_sync_start, .trace_point_enable, .sync_err);
    // ----------
    // Tasks
    // ----------
    task automatic test_done();
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rg(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] exp, input logic xe);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        if (!w) chk(prdata, exp);
        chk(pslverr, xe);
        {psel, penable} <= 2'h0;
        #1;
    endtask
    task automatic wp(input logic [2:0] k, input logic [3:0] e, input logic [6:0] f,
        input logic ev);
        @(posedge pclk);
        {core_wp_valid, core_kind, core_exc, core_commit} <= {1'h1, k, e, 2'h2};
        {core_prohibit, nonsecure_flag, core_monitor, core_tbit, core_jbit, core_compact,
            core_cond} <= f;
        @(posedge pclk);
        {core_wp_valid, core_commit} <= 3'h0;
        #1;
        chk(trace_point_valid, ev);
        if (ev) sent++;
    endtask
    // ----------
    // Sequence
    // ----------
    initial forever #50 pclk = ~pclk;
    initial begin
        forever begin
            @(posedge pclk);
            cycles++;
            if (cycles > 2000) begin
                bad_count++;
                test_done();
            end
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        rg(1'h0, `OFS_CTRL, 32'h0, 32'h0, 1'h0);
        rg(1'h0, `OFS_STATUS, 32'h0, 32'h0000_0005, 1'h0);
        rg(1'h0, 8'h10, 32'h0, 32'h0, 1'h1);
        rg(1'h1, `OFS_STATUS, 32'h0000_00FF, 32'h0, 1'h1);
        for (int k = 0; k < 4; k++) begin
            wp(3'(k), EXC_NONE, {6'h00, k[0]}, 1'h1);
            chk(trace_context_ident, 32'h0);
            chk(trace_point_kind, 3'(k));
            chk(trace_cond_passed, k[0] | k[1]);
            chk(trace_link_update, k < 2);
            chk(trace_last_addr, (k == 2) ? core_lr : core_pc);
            chk(trace_commit_count, 2'h2);
        end
        rg(1'h0, `OFS_COUNT, 32'h0, sent, 1'h0);
        foreach (excs[i]) begin
            wp(KIND_EXCEPT, excs[i], 7'h00, 1'h1);
            chk(trace_exception_kind, excs[i]);
            chk(trace_last_addr, (excs[i] == EXC_RESET) ? 32'h0 : core_lr);
        end
        for (int i = 0; i < 4; i++) begin
            wp(KIND_INDIRECT, EXC_NONE, {1'h0, i[1], i[0], i[1], i[0], i[0], 1'h1}, 1'h1);
            chk(trace_dest_addr, {30'h3FFF_FFFF, i[1], i[0]});
            chk({dest_compact_bit, dest_bytecode_bit}, i[1:0]);
            chk(trace_wide_instr, i[0]);
            chk(trace_nonsecure, i[1] & ~i[0]);
        end
        wp(KIND_BAD6, EXC_NONE, 7'h00, 1'h0);
        wp(KIND_BAD7, EXC_NONE, 7'h00, 1'h0);
        wp(KIND_DIRECT, EXC_NONE, 7'h40, 1'h1);
        chk(trace_blocked, 1'h1);
        chk(trace_dest_addr, 32'h0);
        wp(KIND_DIRECT, EXC_NONE, 7'h40, 1'h0);
        wp(KIND_DIRECT, EXC_NONE, 7'h00, 1'h1);
        chk({trace_sync_start, trace_blocked}, 2'h2);
        wp(KIND_DBG_ENTRY, EXC_NONE, 7'h00, 1'h1);
        chk(trace_dest_addr, 32'h0);
        wp(KIND_DIRECT, EXC_NONE, 7'h00, 1'h1);
        chk(trace_point_kind, KIND_DBG_EXIT);
        chk(trace_dest_addr, 32'h0);
        allow <= 1'h0;
        wp(KIND_DIRECT, EXC_NONE, 7'h00, 1'h0);
        chk(trace_commit_count, 2'h0);
        allow <= 1'h1;
        rg(1'h1, `OFS_CONTEXT, 32'hA5A5_1234, 32'h0, 1'h0);
        chk(trace_context_ident, 32'hA5A5_1234);
        rg(1'h1, `OFS_CTRL, 32'h0000_0002, 32'h0, 1'h0);
        chk(trace_context_ident, 32'h0);
        rg(1'h0, `OFS_CTRL, 32'h0, 32'h0, 1'h0);
        @(posedge pclk);
        core_spec_push <= 1'h1;
        repeat (2) @(posedge pclk);
        core_spec_push <= 1'h0;
        core_spec_pop <= 1'h1;
        @(posedge pclk);
        core_spec_pop <= 1'h0;
        #1;
        chk(trace_queue_empty, 1'h0);
        rg(1'h0, `OFS_STATUS, 32'h0, 32'h0000_0104, 1'h0);
        @(posedge pclk);
        core_flush <= 1'h1;
        @(posedge pclk);
        core_flush <= 1'h0;
        #1;
        chk({trace_queue_empty, trace_discard}, 2'h3);
        rg(1'h1, `OFS_CTRL, 32'h1, 32'h0, 1'h0);
        rg(1'h0, `OFS_CTRL, 32'h0, 32'h1, 1'h0);
        wp(KIND_BARRIER, EXC_NONE, 7'h00, 1'h1);
        chk(trace_blocked, 1'h1);
        rg(1'h1, `OFS_CTRL, 32'h0, 32'h0, 1'h0);
        wp(KIND_BARRIER, EXC_NONE, 7'h00, 1'h1);
        chk({trace_sync_start, trace_blocked}, 2'h2);
        @(posedge pclk);
        {invasive_dbg_en, noninvasive_dbg_en} <= 2'h0;
        repeat (3) @(posedge pclk);
        #1;
        chk(trace_blocked, 1'h1);
        chk(sync_err, 1'h0);
        test_done();
    end
endmodule
bind waypoint_trace_port waypoint_trace_port_props u_waypoint_trace_port_props (.pclk, .presetn,
    .core_wp_valid, .core_kind, .core_commit, .core_link, .core_cond, .core_monitor,
    .nonsecure_flag, .core_flush, .core_spec_push, .trace_point_enable, .trace_point_valid,
    .trace_point_kind, .trace_commit_count, .trace_exception_kind, .trace_link_update,
    .trace_last_addr, .trace_cond_passed, .dest_bytecode_bit, .dest_compact_bit,
    .trace_dest_addr, .trace_blocked, .trace_nonsecure, .trace_queue_empty, .trace_discard);
